// ==== src/imf_bus_monitor.sv ====
/*
 * Bus monitor: brings scl and sda into the core clock domain and
 * reports START and STOP conditions seen on the wire as pulses.
 * Assumes both lines are open-drain and pulled up outside.
 */
`timescale 1ns/1ps
module imf_bus_monitor
   import imf_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic scl_i,
   input wire logic sda_i,
   output imf_bus_t bus_o
);
   logic [1:0] scl_meta, sda_meta;
   logic scl_q, sda_q;
   imf_bus_t next_bus;

   always_comb begin
      next_bus.scl = scl_meta[1];
      next_bus.sda = sda_meta[1];
      // only the second stage and its delayed copy are compared
      next_bus.start = scl_meta[1] && scl_q && sda_q && !sda_meta[1];
      next_bus.stop = scl_meta[1] && scl_q && !sda_q && sda_meta[1];
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         scl_meta <= 2'h3;
         sda_meta <= 2'h3;
         scl_q <= 1'b1;
         sda_q <= 1'b1;
         bus_o <= '{scl: 1'b1, sda: 1'b1, start: 1'b0, stop: 1'b0};
      end else begin
         scl_meta <= {scl_meta[0], scl_i};
         sda_meta <= {sda_meta[0], sda_i};
         scl_q <= scl_meta[1];
         sda_q <= sda_meta[1];
         bus_o <= next_bus;
      end
   end
endmodule : imf_bus_monitor

// ==== src/imf_event_ctrl.sv ====
/*
 * I2C master condition generator with self-clearing event flags and a
 * glitch-free interrupt request. Register port: address, write data,
 * write and read strobes, read data one cycle later.
 * Assumes global_irq_enable_i comes from the processor on clk_i.
 */
// Chosen here: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
// Summary of operation
// R1: START and repeated START setup and hold times are met at every divider.
// R2: a stretching slave is waited for, so a START never shortens a phase.
// R3: software may keep scl below 50 kHz, which this design does not need.
// R4: start, stop and nack flags are cleared by hardware on bus events.
// R5: a flag with its enable set is pending whatever the global enable.
// R6: a flag cleared right after the global enable rises never drops irq.
// R7: software may clear the local enables before the global enable.
// R8: a request present at the global enable rise holds until status read.
module imf_event_ctrl
   import imf_pkg::*;
#(
   parameter int DIV_W = CNT_W
)(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [3:0] addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [31:0] rdata_o,
   input wire logic scl_i,
   output logic scl_o,
   output logic scl_oe_o,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_o,
   input wire logic global_irq_enable_i,
   output logic irq_o
);
   // refused at elaboration: divider field must fit the phase counter
   if (DIV_W < 8 || DIV_W > CNT_W) begin : g_div_w_check
      $error("imf_event_ctrl: DIV_W out of range");
   end

   typedef enum logic [3:0] {
      ST_IDLE, ST_RS_REL, ST_RS_RISE, ST_STA_SU, ST_STA_HD, ST_STA_LOW,
      ST_STO_LOW, ST_STO_RISE, ST_STO_SU, ST_STO_BUF,
      ST_ACK_LOW, ST_ACK_RISE, ST_ACK_HIGH
   } imf_state_t;

   imf_bus_t bus;
   imf_state_t state, next_state;
   logic [CNT_W-1:0] cnt, next_cnt;
   logic scl_low, next_scl_low;
   logic sda_low, next_sda_low;
   logic [2:0] flags, next_flags;
   logic [2:0] mask, next_mask;
   logic [2:0] held, next_held;
   logic [DIV_W-1:0] div, next_div;
   logic global_irq_enable_q;
   logic next_irq;
   logic [31:0] next_rdata;
   logic nack_set;

   // a phase lasts the programmed half period, never under its minimum
   function automatic logic [CNT_W-1:0] phase(input logic [DIV_W-1:0] d,
                                              input int tmin);
      logic [CNT_W-1:0] m;
      m = CNT_W'(tmin);
      if (CNT_W'(d) > m)
         m = CNT_W'(d);
      return m - 16'h0001;
   endfunction : phase

   imf_bus_monitor u_mon (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .scl_i(scl_i),
      .sda_i(sda_i),
      .bus_o(bus)
   );

   always_comb begin
      next_state = state;
      next_cnt = (cnt != '0) ? cnt - 16'h0001 : cnt;
      next_scl_low = scl_low;
      next_sda_low = sda_low;
      nack_set = 1'b0;
      case (state)
         ST_IDLE: begin
            if (wr_i && addr_i == OFS_CMD) begin
               if (wdata_i[CMD_START]) begin
                  next_state = ST_RS_REL;
                  next_cnt = phase(div, T_LOW_CYC);
               end else if (wdata_i[CMD_STOP]) begin
                  next_state = ST_STO_LOW;
                  next_cnt = phase(div, T_LOW_CYC);
               end else if (wdata_i[CMD_ACK]) begin
                  next_state = ST_ACK_LOW;
                  next_cnt = phase(div, T_LOW_CYC);
               end
            end
         end
         ST_RS_REL: begin
            next_sda_low = 1'b0;
            if (cnt == '0) begin
               next_state = ST_RS_RISE;
            end
         end
         ST_RS_RISE: begin
            next_scl_low = 1'b0;
            // clock stretching: setup counts only once scl is high
            if (bus.scl && !scl_low) begin // R2
               next_state = ST_STA_SU;
               next_cnt = phase(div, T_SU_STA_CYC); // R1
            end
         end
         ST_STA_SU: begin
            if (cnt == '0) begin
               next_state = ST_STA_HD;
               next_sda_low = 1'b1;
               next_cnt = phase(div, T_HD_STA_CYC); // R1
            end
         end
         ST_STA_HD: begin
            if (cnt == '0) begin
               next_state = ST_STA_LOW;
               next_scl_low = 1'b1;
               next_cnt = phase(div, T_LOW_CYC);
            end
         end
         ST_STA_LOW: begin
            if (cnt == '0)
               next_state = ST_IDLE;
         end
         ST_STO_LOW: begin
            next_sda_low = 1'b1;
            if (cnt == '0)
               next_state = ST_STO_RISE;
         end
         ST_STO_RISE: begin
            next_scl_low = 1'b0;
            if (bus.scl && !scl_low) begin // R2
               next_state = ST_STO_SU;
               next_cnt = phase(div, T_SU_STO_CYC);
            end
         end
         ST_STO_SU: begin
            if (cnt == '0) begin
               next_state = ST_STO_BUF;
               next_sda_low = 1'b0;
               next_cnt = phase(div, T_BUF_CYC);
            end
         end
         ST_STO_BUF: begin
            if (cnt == '0)
               next_state = ST_IDLE;
         end
         ST_ACK_LOW: begin
            next_sda_low = 1'b0;
            if (cnt == '0)
               next_state = ST_ACK_RISE;
         end
         ST_ACK_RISE: begin
            next_scl_low = 1'b0;
            if (bus.scl && !scl_low) begin // R2
               next_state = ST_ACK_HIGH;
               next_cnt = phase(div, T_HIGH_CYC);
            end
         end
         ST_ACK_HIGH: begin
            if (cnt == '0) begin
               nack_set = bus.sda;
               next_scl_low = 1'b1;
               next_state = ST_IDLE;
            end
         end
         default: begin
            next_state = ST_IDLE;
            next_scl_low = 1'b0;
            next_sda_low = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         state <= ST_IDLE;
         cnt <= '0;
         scl_low <= 1'b0;
         sda_low <= 1'b0;
      end else begin
         state <= next_state;
         cnt <= next_cnt;
         scl_low <= next_scl_low;
         sda_low <= next_sda_low;
      end
   end

   // flags, enables, divider and the held request
   always_comb begin
      next_flags = flags;
      next_mask = mask;
      next_div = div;
      next_held = held;
      // bus events retire the opposite flags
      if (bus.stop)
         next_flags[FLG_START] = 1'b0; // R4
      if (bus.start) begin
         next_flags[FLG_STOP] = 1'b0; // R4
         next_flags[FLG_NACK] = 1'b0; // R4
      end
      if (wr_i && addr_i == OFS_STATUS)
         next_flags = next_flags & ~wdata_i[2:0];
      if (wr_i && addr_i == OFS_MASK)
         next_mask = wdata_i[2:0];
      if (wr_i && addr_i == OFS_DIV)
         next_div = wdata_i[DIV_W-1:0];
      // sets win over any clear in the same cycle
      if (bus.start)
         next_flags[FLG_START] = 1'b1;
      if (bus.stop)
         next_flags[FLG_STOP] = 1'b1;
      if (nack_set)
         next_flags[FLG_NACK] = 1'b1;
      // freeze the cause seen as the global enable rises
      if (rd_i && addr_i == OFS_STATUS)
         next_held = '0; // R8
      if (global_irq_enable_i && !global_irq_enable_q && |(flags & mask))
         next_held = held | (flags & mask); // R6
      // pending needs only flag and enable, not the global enable
      next_irq = |(next_flags & next_mask) | |next_held; // R5
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         flags <= '0;
         mask <= MASK_RST;
         div <= DIV_W'(DIV_RST);
         held <= '0;
         global_irq_enable_q <= 1'b0;
         irq_o <= 1'b0;
      end else begin
         flags <= next_flags;
         mask <= next_mask;
         div <= next_div;
         held <= next_held;
         global_irq_enable_q <= global_irq_enable_i;
         irq_o <= next_irq;
      end
   end

   // read data stand only in the cycle after the strobe
   always_comb begin
      next_rdata = 32'h0000_0000;
      if (rd_i) begin
         case (addr_i)
            OFS_STATUS: begin
               next_rdata[2:0] = flags;
               next_rdata[STS_BUSY] = (state != ST_IDLE);
               next_rdata[STS_HELD +: 3] = held;
            end
            OFS_MASK: next_rdata[2:0] = mask;
            OFS_DIV: next_rdata[DIV_W-1:0] = div;
            default: next_rdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         rdata_o <= 32'h0000_0000;
         scl_o <= 1'b0;
         sda_o <= 1'b0;
         scl_oe_o <= 1'b0;
         sda_oe_o <= 1'b0;
      end else begin
         rdata_o <= next_rdata;
         scl_o <= 1'b0;
         sda_o <= 1'b0;
         scl_oe_o <= next_scl_low;
         sda_oe_o <= next_sda_low;
      end
   end
endmodule : imf_event_ctrl

// ==== src/imf_pkg.sv ====
/*
 * Package for the i2c master event-flag block: register map, field
 * positions, reset values, bus timing minima and shared types.
 * Assumes a 10 MHz core clock shared with the processor.
 */
package imf_pkg;
   localparam int CLK_NS = 100;
   // bus timing minima, nanoseconds, standard mode
   localparam int T_SU_STA_NS = 4700;
   localparam int T_HD_STA_NS = 4000;
   localparam int T_LOW_NS = 4700;
   localparam int T_HIGH_NS = 4000;
   localparam int T_SU_STO_NS = 4000;
   localparam int T_BUF_NS = 4700;
   // least times round up to whole cycles
   localparam int T_SU_STA_CYC = (T_SU_STA_NS + CLK_NS - 1) / CLK_NS;
   localparam int T_HD_STA_CYC = (T_HD_STA_NS + CLK_NS - 1) / CLK_NS;
   localparam int T_LOW_CYC = (T_LOW_NS + CLK_NS - 1) / CLK_NS;
   localparam int T_HIGH_CYC = (T_HIGH_NS + CLK_NS - 1) / CLK_NS;
   localparam int T_SU_STO_CYC = (T_SU_STO_NS + CLK_NS - 1) / CLK_NS;
   localparam int T_BUF_CYC = (T_BUF_NS + CLK_NS - 1) / CLK_NS;

   localparam int CNT_W = 16;
   localparam logic [3:0] OFS_CMD = 4'h0;
   localparam logic [3:0] OFS_STATUS = 4'h4;
   localparam logic [3:0] OFS_MASK = 4'h8;
   localparam logic [3:0] OFS_DIV = 4'hC;

   // command bits of the command register (write only)
   localparam int CMD_START = 0;
   localparam int CMD_STOP = 1;
   localparam int CMD_ACK = 2;
   // status layout: flags [2:0], busy [3], held cause [6:4]
   localparam int FLG_START = 0;
   localparam int FLG_STOP = 1;
   localparam int FLG_NACK = 2;
   localparam int STS_BUSY = 3;
   localparam int STS_HELD = 4;

   localparam logic [2:0] MASK_RST = 3'h0;
   // half period of scl in clock cycles: 50 gives 100 kHz
   localparam logic [CNT_W-1:0] DIV_RST = 16'h0032;

   typedef struct packed {
      logic scl;
      logic sda;
      logic start;
      logic stop;
   } imf_bus_t;
endpackage : imf_pkg

// ==== testbench/imf_event_ctrl_asserts.sv ====
/*
 * Port checker for imf_event_ctrl, bound at the foot of this file.
 * Assumes scl_i and sda_i carry the resolved open-drain wire levels.
 */
`timescale 1ns/1ps
module imf_event_ctrl_asserts
   import imf_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [3:0] addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [31:0] rdata_o,
   input wire logic scl_i,
   input wire logic scl_o,
   input wire logic scl_oe_o,
   input wire logic sda_i,
   input wire logic sda_o,
   input wire logic sda_oe_o,
   input wire logic global_irq_enable_i,
   input wire logic irq_o
);
   logic [7:0] hi_cnt;
   logic [7:0] lo_cnt;
   logic [2:0] mask_q;
   logic sts_rd;
   assign sts_rd = rd_i && addr_i == OFS_STATUS;
   // saturating, so long idle spans never wrap into a false short phase
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         hi_cnt <= 8'h00;
         lo_cnt <= 8'h00;
         mask_q <= MASK_RST;
      end else begin
         hi_cnt <= !scl_i ? 8'h00 : hi_cnt + 8'(hi_cnt != 8'hFF);
         lo_cnt <= sda_i ? 8'h00 : lo_cnt + 8'(lo_cnt != 8'hFF);
         if (wr_i && addr_i == OFS_MASK) begin
            mask_q <= wdata_i[2:0];
         end
      end
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   property p_su;
      $rose(sda_oe_o) && $past(scl_i) |-> hi_cnt >= T_SU_STA_CYC;
   endproperty
   a_su: assert property (p_su) else $error("start setup short");
   property p_hd;
      $rose(scl_oe_o) && $past(scl_i) && !$past(sda_i)
         |-> lo_cnt >= T_HD_STA_CYC;
   endproperty
   a_hd: assert property (p_hd) else $error("start hold short");
   property p_hi;
      $rose(scl_oe_o) && $past(scl_i) |-> hi_cnt >= T_HIGH_CYC;
   endproperty
   a_hi: assert property (p_hi) else $error("scl high cut short");
   property p_drv;
      scl_o == 1'b0 && sda_o == 1'b0;
   endproperty
   a_drv: assert property (p_drv) else $error("pin drives high");
   property p_rd;
      !$past(rd_i) |-> rdata_o == 32'h0;
   endproperty
   a_rd: assert property (p_rd) else $error("read data outside slot");
   property p_pend;
      // read data show the flags of the cycle before, so compare that cycle
      $past(sts_rd) && |(rdata_o[2:0] & $past(mask_q)) |-> $past(irq_o);
   endproperty
   a_pend: assert property (p_pend) else $error("pending irq low");
   property p_gie;
      $rose(global_irq_enable_i) && irq_o && !sts_rd |=> irq_o;
   endproperty
   a_gie: assert property (p_gie) else $error("irq lost at enable");
   property p_held;
      $rose(global_irq_enable_i) && irq_o && !sts_rd ##1 !sts_rd [*6]
         |-> irq_o;
   endproperty
   a_held: assert property (p_held) else $error("irq not held");
   c_start: cover property ($rose(sda_oe_o) && $past(scl_i));
   c_race: cover property ($rose(global_irq_enable_i) && irq_o);
   c_nack: cover property ($past(sts_rd) && rdata_o[FLG_NACK]);
endmodule : imf_event_ctrl_asserts

bind imf_event_ctrl imf_event_ctrl_asserts u_chk (.clk_i, .rst_i,
   .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .scl_i, .scl_o, .scl_oe_o,
   .sda_i, .sda_o, .sda_oe_o, .global_irq_enable_i, .irq_o);

// ==== testbench/imf_event_ctrl_tb.sv ====
/*
 * Bench for imf_event_ctrl with the slave model on the wires.
 * Assumes the block's 10 MHz clock and one master on the bus.
 */
`timescale 1ns/1ps
module imf_event_ctrl_tb
   import imf_pkg::*;
;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [3:0] addr = 4'h0;
   logic [31:0] wdata = 32'h0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic global_irq_enable = 1'b0;
   logic stretch = 1'b0;
   logic ack = 1'b0;
   logic [31:0] rdata;
   logic [31:0] v;
   logic scl, sda, scl_oe, sda_oe, irq;
   int mismatches = 0;
   int n_checks = 0;
   imf_event_ctrl uut (.clk_i, .rst_i, .addr_i(addr), .wdata_i(wdata),
      .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .scl_i(scl), .scl_o(),
      .scl_oe_o(scl_oe), .sda_i(sda), .sda_o(), .sda_oe_o(sda_oe),
      .global_irq_enable_i(global_irq_enable), .irq_o(irq));
   imf_i2c_slave peer (.scl_oe_i(scl_oe), .sda_oe_i(sda_oe),
      .stretch_i(stretch), .ack_i(ack), .scl_o(scl), .sda_o(sda));
   initial forever #50 clk_i = ~clk_i;
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : print_verdict
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic chk_irq(input logic exp);
      n_checks++;
      if (irq !== exp) begin
         mismatches++;
         $display("ERROR %0t irq %b expected %b", $time, irq, exp);
      end
   endtask : chk_irq
   task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_i);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk_i);
      wr <= 1'b0;
   endtask : wr_reg
   task automatic rd_reg(input logic [3:0] a);
      @(posedge clk_i);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk_i);
      rd <= 1'b0;
      @(negedge clk_i);
      v = rdata;
   endtask : rd_reg
   task automatic idle();
      v = 32'h8;
      for (int i = 0; i < 3000 && v[STS_BUSY]; i++) rd_reg(OFS_STATUS);
   endtask : idle
   task automatic run(input int b, input logic [31:0] exp);
      wr_reg(OFS_CMD, 32'h1 << b);
      idle();
      chk(v, exp);
   endtask : run
   task automatic t_regs();
      logic [3:0] a [5] = '{OFS_STATUS, OFS_MASK, OFS_DIV, OFS_CMD, 4'h2};
      logic [31:0] e [5] = '{32'h0, 32'h0, {16'h0, DIV_RST}, 32'h0, 32'h0};
      wr_reg(4'h2, 32'hFFFF_FFFF);
      foreach (a[i]) begin
         rd_reg(a[i]);
         chk(v, e[i]);
      end
   endtask : t_regs
   task automatic t_link();
      wr_reg(OFS_DIV, 32'hA);
      run(CMD_START, 32'h1);
      stretch <= 1'b1;
      run(CMD_ACK, 32'h5);
      stretch <= 1'b0;
      ack <= 1'b1;
      run(CMD_START, 32'h1);
      run(CMD_ACK, 32'h1);
      ack <= 1'b0;
      wr_reg(OFS_DIV, 32'h78);
      run(CMD_STOP, 32'h2);
      wr_reg(OFS_STATUS, 32'h2);
      rd_reg(OFS_STATUS);
      chk(v, 32'h0);
   endtask : t_link
   task automatic t_mask();
      wr_reg(OFS_MASK, 32'h1);
      run(CMD_START, 32'h1);
      chk_irq(1'b1);
      wr_reg(OFS_MASK, 32'h0);
      repeat (2) @(negedge clk_i);
      chk_irq(1'b0);
      wr_reg(OFS_MASK, 32'h1);
   endtask : t_mask
   // enable lands inside the flag's hardware clear; k = 2 on the same edge
   task automatic t_race();
      for (int k = 0; k < 3; k++) begin
         wr_reg(OFS_CMD, 32'h1 << CMD_STOP);
         for (int i = 0; i < 999 && !sda; i++) @(posedge clk_i);
         chk({31'h0, sda}, 32'h1);
         repeat (k) @(posedge clk_i);
         global_irq_enable <= 1'b1;
         repeat (8) @(negedge clk_i);
         chk_irq(1'b1);
         idle();
         repeat (2) @(negedge clk_i);
         chk_irq(1'b0);
         @(posedge clk_i);
         global_irq_enable <= 1'b0;
         run(CMD_START, 32'h1);
      end
   endtask : t_race
   task automatic t_sw();
      wr_reg(OFS_MASK, 32'h0);
      @(posedge clk_i);
      global_irq_enable <= 1'b1;
      wr_reg(OFS_MASK, 32'h7);
      repeat (2) @(negedge clk_i);
      chk_irq(1'b1);
      wr_reg(OFS_STATUS, 32'h7);
      rd_reg(OFS_STATUS);
      chk(v, 32'h0);
      repeat (2) @(negedge clk_i);
      chk_irq(1'b0);
   endtask : t_sw
   initial begin
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      t_regs();
      t_link();
      t_mask();
      t_race();
      t_sw();
      print_verdict();
   end
   // about seven times the longest expected run
   initial begin
      #3000000;
      mismatches++;
      print_verdict();
   end
endmodule : imf_event_ctrl_tb

// ==== testbench/imf_i2c_slave.sv ====
/*
 * I2C slave stand-in: pulled-up open-drain wires, clock stretch, ack.
 * Assumes the master only drives the pull-down enables.
 */
`timescale 1ns/1ps
module imf_i2c_slave (
   input wire logic scl_oe_i,
   input wire logic sda_oe_i,
   input wire logic stretch_i,
   input wire logic ack_i,
   output logic scl_o,
   output logic sda_o
);
   logic hold_scl = 1'b0;
   logic pull_sda = 1'b0;
   assign scl_o = !(scl_oe_i || hold_scl);
   assign sda_o = !(sda_oe_i || pull_sda);
   // acks every other low phase, so the next fall always releases sda
   always @(negedge scl_o) begin
      pull_sda <= ack_i && !pull_sda;
      if (stretch_i) begin
         hold_scl = 1'b1;
         #8000 hold_scl = 1'b0;
      end
   end
endmodule : imf_i2c_slave
